// ### dic_pkg.sv
// Package for the digital input conditioning block: object map, field
// layout, reset values, routing source codes and sample timing.
// Assumes a single 100 MHz controller clock; every user writes dic_pkg::name.
package dic_pkg;

  // ----------------------------------------------------------------
  // Object map (index and subindex)
  // ----------------------------------------------------------------
  localparam logic [15:0] OBJ_CFG_INDEX = 16'h3240;
  localparam logic [15:0] OBJ_IMAGE_INDEX = 16'h60FD;
  localparam logic [15:0] OBJ_ROUTE_INDEX = 16'h3242;
  localparam logic [7:0] SUB_SFE = 8'h01;
  localparam logic [7:0] SUB_INV = 8'h02;
  localparam logic [7:0] SUB_FORCE_EN = 8'h03;
  localparam logic [7:0] SUB_FORCE_VAL = 8'h04;
  localparam logic [7:0] SUB_RAW = 8'h05;
  localparam logic [7:0] SUB_THRESH = 8'h06;
  localparam logic [7:0] SUB_DIFF = 8'h07;
  localparam logic [7:0] SUB_ROUTE_EN = 8'h08;
  localparam logic [7:0] SUB_IMAGE = 8'h00;
  localparam logic [7:0] SUB_ROUTE_FIRST = 8'h01;
  localparam logic [7:0] SUB_ROUTE_LAST = 8'h20;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int NUM_INPUTS = 6;
  localparam int NUM_PAIRS = 3;
  localparam int ROUTE_ENTRIES = 32;
  localparam int IMG_LEVEL_LSB = 16;
  localparam int SF_NEG_LIMIT = 0;
  localparam int SF_POS_LIMIT = 1;
  localparam int SF_HOME = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [7:0] RESET_ROUTE = 8'h00;

  // ----------------------------------------------------------------
  // Routing source codes
  // ----------------------------------------------------------------
  localparam logic [6:0] SRC_CONST = 7'h00;
  localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
  localparam logic [6:0] SRC_ENC_A = 7'h44;
  localparam logic [6:0] SRC_ENC_B = 7'h45;
  localparam logic [6:0] SRC_ENC_IDX = 7'h46;
  localparam logic [6:0] SRC_NET = 7'h48;
  localparam int SRC_INVERT_BIT = 7;

  // ----------------------------------------------------------------
  // Sample timing
  // ----------------------------------------------------------------
  localparam int SAMPLE_PERIOD_MS = 1;
  localparam int CLOCK_FREQ_HZ = 100_000_000;
  localparam int MS_CYCLES = SAMPLE_PERIOD_MS * (CLOCK_FREQ_HZ / 1000);

  typedef enum logic {
    MODE_NORMAL = 1'b0,
    MODE_ROUTING = 1'b1
  } dic_mode_t;

  // Settings that steer the conditioning path
  typedef struct packed {
    logic [31:0] sfe;
    logic [31:0] inv;
    logic [31:0] force_en;
    logic [31:0] force_val;
    logic [31:0] thresh;
    logic diff;
    dic_mode_t mode;
  } dic_cfg_t;

endpackage

// ### dic_input_cond.sv
// Digital input conditioning: millisecond sampling, forcing, inversion,
// special functions, threshold and differential select, input routing.
// Assumes pins are synchronous to CLOCK_IN; objects reached by index/subindex.
`timescale 1ns/1ps

module dic_input_cond #(
  parameter int MS_CYCLES = dic_pkg::MS_CYCLES
) (
  input wire logic CLOCK_IN, // 100 MHz clock
  input wire logic RESET_IN, // Synchronous reset, active high
  input wire logic [5:0] PIN_IN, // Input pins 2..7 in pin order
  input wire logic ENC_A_IN, // Encoder channel A
  input wire logic ENC_B_IN, // Encoder channel B
  input wire logic ENC_IDX_IN, // Encoder index
  input wire logic NET_ACTIVE_IN, // Network active status
  input wire logic STEP_DIR_MODE_IN, // Pulse-direction mode active
  input wire logic OBJ_WR_IN, // Object write strobe
  input wire logic OBJ_RD_IN, // Object read strobe
  input wire logic [15:0] OBJ_INDEX_IN, // Object index
  input wire logic [7:0] OBJ_SUB_IN, // Object subindex
  input wire logic [31:0] OBJ_WDATA_IN, // Write data
  output logic [31:0] OBJ_RDATA_OUT, // Read data
  output logic OBJ_ACK_OUT, // Access done pulse
  output logic OBJ_ERR_OUT, // Access refused pulse
  output logic [31:0] IMAGE_OUT, // Digital input image
  output logic [5:0] THRESH_24V_OUT, // Per input 24 V threshold
  output logic DIFF_MODE_OUT, // Differential receivers on
  output logic NEG_LIMIT_OUT, // Negative limit active
  output logic POS_LIMIT_OUT, // Positive limit active
  output logic HOME_OUT, // Home switch active
  output logic STEP_OUT, // Step pulse level
  output logic DIR_OUT // Direction level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int CW = $clog2(MS_CYCLES + 1);
  localparam logic [CW-1:0] MS_LAST = CW'(MS_CYCLES - 1);

  dic_pkg::dic_cfg_t cfg, next_cfg;
  logic [7:0] route [dic_pkg::ROUTE_ENTRIES];
  logic [7:0] next_route [dic_pkg::ROUTE_ENTRIES];
  logic [7:0] route_dflt [dic_pkg::ROUTE_ENTRIES];
  logic [CW-1:0] ms_cnt, next_ms_cnt;
  logic tick;
  logic [5:0] raw, next_raw;
  logic [31:0] image, next_image;
  logic [31:0] route_img;
  logic [5:0] pin_level, forced, level;
  logic [15:0] phys;
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack, err, next_err;
  logic [5:0] thresh_q;
  logic diff_q, neg_q, pos_q, home_q, step_q, dir_q;
  logic cfg_hit, img_hit, rt_hit, activate;
  logic [4:0] rt_sel;

  // ----------------------------------------------------------------
  // Millisecond strobe
  // ----------------------------------------------------------------
  // Counter starts at zero so the first sample is a full period away
  always_comb begin
    tick = (ms_cnt == MS_LAST);
    next_ms_cnt = tick ? '0 : ms_cnt + CW'(1);
  end

  // ----------------------------------------------------------------
  // Pin front end and conditioning
  // ----------------------------------------------------------------
  // Pair k uses pins 2k+2 (minus) and 2k+3 (plus); upper inputs idle
  always_comb begin
    pin_level = PIN_IN;
    if (cfg.diff) begin
      for (int k = 0; k < dic_pkg::NUM_PAIRS; k++) begin
        pin_level[k] = PIN_IN[2*k+1] & ~PIN_IN[2*k];
      end
      pin_level[5:3] = 3'b000;
    end
    forced = (cfg.force_en[5:0] & cfg.force_val[5:0]) |
             (~cfg.force_en[5:0] & pin_level);
    level = forced ^ cfg.inv[5:0];
    phys = {10'h000, forced};
  end

  // ----------------------------------------------------------------
  // Routing: per-bit source decode and activation defaults
  // ----------------------------------------------------------------
  // Physical sources are taken after forcing so defaults stay exact
  for (genvar i = 0; i < dic_pkg::ROUTE_ENTRIES; i++) begin : g_route
    logic [6:0] code;
    logic src;
    always_comb begin
      code = route[i][6:0];
      if (code == dic_pkg::SRC_CONST) begin
        src = 1'b0;
      end else if (code <= dic_pkg::SRC_PHYS_LAST) begin
        src = phys[4'(code - 7'h01)];
      end else if (code == dic_pkg::SRC_ENC_A) begin
        src = ENC_A_IN;
      end else if (code == dic_pkg::SRC_ENC_B) begin
        src = ENC_B_IN;
      end else if (code == dic_pkg::SRC_ENC_IDX) begin
        src = ENC_IDX_IN;
      end else if (code == dic_pkg::SRC_NET) begin
        src = NET_ACTIVE_IN;
      end else begin
        src = 1'b0;
      end
      route_img[i] = src ^ route[i][dic_pkg::SRC_INVERT_BIT];
      // Defaults rebuild the normal path: input number plus its inversion
      if (i >= dic_pkg::IMG_LEVEL_LSB && i < dic_pkg::IMG_LEVEL_LSB + dic_pkg::NUM_INPUTS) begin
        route_dflt[i] = {cfg.inv[5'(i - dic_pkg::IMG_LEVEL_LSB)],
                         7'(i - dic_pkg::IMG_LEVEL_LSB + 1)};
      end else if (i <= dic_pkg::SF_HOME) begin
        route_dflt[i] = (cfg.sfe[i] && !(STEP_DIR_MODE_IN && i != 0)) ?
                        {cfg.inv[i], 7'(i + 1)} : dic_pkg::RESET_ROUTE;
      end else begin
        route_dflt[i] = dic_pkg::RESET_ROUTE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Image and raw word
  // ----------------------------------------------------------------
  // Pulse-direction mode hands inputs 2 and 3 to the step logic
  always_comb begin
    next_raw = raw;
    next_image = image;
    if (tick) begin
      next_raw = pin_level;
      if (cfg.mode == dic_pkg::MODE_ROUTING) begin
        next_image = route_img;
      end else begin
        next_image = dic_pkg::RESET_WORD;
        next_image[dic_pkg::IMG_LEVEL_LSB +: dic_pkg::NUM_INPUTS] = level;
        next_image[dic_pkg::SF_NEG_LIMIT] = level[0] & cfg.sfe[0];
        next_image[dic_pkg::SF_POS_LIMIT] = level[1] & cfg.sfe[1] & ~STEP_DIR_MODE_IN;
        next_image[dic_pkg::SF_HOME] = level[2] & cfg.sfe[2] & ~STEP_DIR_MODE_IN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Object access
  // ----------------------------------------------------------------
  always_comb begin
    cfg_hit = (OBJ_INDEX_IN == dic_pkg::OBJ_CFG_INDEX) &&
              (OBJ_SUB_IN >= dic_pkg::SUB_SFE) && (OBJ_SUB_IN <= dic_pkg::SUB_ROUTE_EN);
    img_hit = (OBJ_INDEX_IN == dic_pkg::OBJ_IMAGE_INDEX) && (OBJ_SUB_IN == dic_pkg::SUB_IMAGE);
    rt_hit = (OBJ_INDEX_IN == dic_pkg::OBJ_ROUTE_INDEX) &&
             (OBJ_SUB_IN >= dic_pkg::SUB_ROUTE_FIRST) && (OBJ_SUB_IN <= dic_pkg::SUB_ROUTE_LAST);
    rt_sel = 5'(OBJ_SUB_IN - dic_pkg::SUB_ROUTE_FIRST);
    activate = OBJ_WR_IN && cfg_hit && (OBJ_SUB_IN == dic_pkg::SUB_ROUTE_EN) &&
               OBJ_WDATA_IN[0] && (cfg.mode == dic_pkg::MODE_NORMAL);
  end

  // Writes; a write to a read-only object is refused and stores nothing
  always_comb begin
    next_cfg = cfg;
    next_route = route;
    next_ack = OBJ_WR_IN | OBJ_RD_IN;
    next_err = 1'b0;
    next_rdata = rdata;
    if (OBJ_WR_IN) begin
      if (cfg_hit) begin
        case (OBJ_SUB_IN)
          dic_pkg::SUB_SFE: next_cfg.sfe = OBJ_WDATA_IN;
          dic_pkg::SUB_INV: next_cfg.inv = OBJ_WDATA_IN;
          dic_pkg::SUB_FORCE_EN: next_cfg.force_en = OBJ_WDATA_IN;
          dic_pkg::SUB_FORCE_VAL: next_cfg.force_val = OBJ_WDATA_IN;
          dic_pkg::SUB_THRESH: next_cfg.thresh = OBJ_WDATA_IN;
          dic_pkg::SUB_DIFF: next_cfg.diff = OBJ_WDATA_IN[0];
          dic_pkg::SUB_ROUTE_EN: next_cfg.mode = dic_pkg::dic_mode_t'(OBJ_WDATA_IN[0]);
          default: next_err = 1'b1;
        endcase
      end else if (rt_hit) begin
        next_route[rt_sel] = OBJ_WDATA_IN[7:0];
      end else begin
        next_err = 1'b1;
      end
      if (activate) begin
        next_route = route_dflt;
      end
    end else if (OBJ_RD_IN) begin
      next_rdata = dic_pkg::RESET_WORD;
      if (cfg_hit) begin
        case (OBJ_SUB_IN)
          dic_pkg::SUB_SFE: next_rdata = cfg.sfe;
          dic_pkg::SUB_INV: next_rdata = cfg.inv;
          dic_pkg::SUB_FORCE_EN: next_rdata = cfg.force_en;
          dic_pkg::SUB_FORCE_VAL: next_rdata = cfg.force_val;
          dic_pkg::SUB_RAW: next_rdata = {26'h000_0000, raw};
          dic_pkg::SUB_THRESH: next_rdata = cfg.thresh;
          dic_pkg::SUB_DIFF: next_rdata = {31'h0000_0000, cfg.diff};
          dic_pkg::SUB_ROUTE_EN: next_rdata = {31'h0000_0000, cfg.mode};
          default: next_err = 1'b1;
        endcase
      end else if (img_hit) begin
        next_rdata = image;
      end else if (rt_hit) begin
        next_rdata = {24'h00_0000, route[rt_sel]};
      end else begin
        next_err = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      cfg <= '0;
      route <= '{default: dic_pkg::RESET_ROUTE};
      ms_cnt <= '0;
      raw <= '0;
      image <= dic_pkg::RESET_WORD;
      rdata <= dic_pkg::RESET_WORD;
      ack <= 1'b0;
      err <= 1'b0;
      thresh_q <= '0;
      diff_q <= 1'b0;
      neg_q <= 1'b0;
      pos_q <= 1'b0;
      home_q <= 1'b0;
      step_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      cfg <= next_cfg;
      route <= next_route;
      ms_cnt <= next_ms_cnt;
      raw <= next_raw;
      image <= next_image;
      rdata <= next_rdata;
      ack <= next_ack;
      err <= next_err;
      thresh_q <= cfg.thresh[5:0];
      diff_q <= cfg.diff;
      neg_q <= next_image[dic_pkg::SF_NEG_LIMIT];
      pos_q <= next_image[dic_pkg::SF_POS_LIMIT];
      home_q <= next_image[dic_pkg::SF_HOME];
      // Step pulses are far faster than the sample period: no sampling here
      step_q <= STEP_DIR_MODE_IN & pin_level[2];
      dir_q <= STEP_DIR_MODE_IN & pin_level[1];
    end
  end

  always_comb begin
    OBJ_RDATA_OUT = rdata;
    OBJ_ACK_OUT = ack;
    OBJ_ERR_OUT = err;
    IMAGE_OUT = image;
    THRESH_24V_OUT = thresh_q;
    DIFF_MODE_OUT = diff_q;
    NEG_LIMIT_OUT = neg_q;
    POS_LIMIT_OUT = pos_q;
    HOME_OUT = home_q;
    STEP_OUT = step_q;
    DIR_OUT = dir_q;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_activate;
    activate;
  endsequence

  property p_image_on_tick;
    !$stable(image) |-> $past(tick);
  endproperty
  a_image_on_tick: assert property (p_image_on_tick) else $error("image moved off tick");

  property p_tick_spacing;
    tick |=> !tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick twice in a row");

  property p_level_bits;
    tick && cfg.mode == dic_pkg::MODE_NORMAL |=> image[21:16] == $past(level);
  endproperty
  a_level_bits: assert property (p_level_bits) else $error("level bits wrong");

  property p_unused_zero;
    tick && cfg.mode == dic_pkg::MODE_NORMAL |=> image[31:22] == 10'h000 && image[15:3] == 13'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused image bits set");

  property p_sfe_gate;
    tick && cfg.mode == dic_pkg::MODE_NORMAL && !cfg.sfe[0] |=> !image[0];
  endproperty
  a_sfe_gate: assert property (p_sfe_gate) else $error("limit bit while disabled");

  property p_raw;
    tick |=> raw == $past(pin_level);
  endproperty
  a_raw: assert property (p_raw) else $error("raw word not sampled level");

  property p_force;
    tick && cfg.mode == dic_pkg::MODE_NORMAL && cfg.force_en[3] |=>
      image[19] == ($past(cfg.force_val[3]) ^ $past(cfg.inv[3]));
  endproperty
  a_force: assert property (p_force) else $error("forced value ignored");

  property p_thresh;
    ##1 THRESH_24V_OUT == $past(cfg.thresh[5:0]);
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold select lags");

  property p_diff_idle;
    tick && cfg.diff |=> raw[5:3] == 3'b000;
  endproperty
  a_diff_idle: assert property (p_diff_idle) else $error("upper inputs live in pairs");

  property p_defaults;
    s_activate |=> route[16] == {$past(cfg.inv[0]), 7'h01} && cfg.mode == dic_pkg::MODE_ROUTING;
  endproperty
  a_defaults: assert property (p_defaults) else $error("routing defaults wrong");

  property p_route_const;
    tick && cfg.mode == dic_pkg::MODE_ROUTING && route[0] == 8'h80 ##1 1'b1 |-> image[0];
  endproperty
  a_route_const: assert property (p_route_const) else $error("constant one not routed");

endmodule

// ### dic_sw_model.sv
// Model of the switches and pulse sources wired to the six input pins.
// Assumes the bench commands levels and glitches at the clock's rising edge.
`timescale 1ns/1ps

module dic_sw_model (
  input wire logic clk_in, // Bench clock
  input wire logic [5:0] level_in, // Steady switch levels
  input wire logic glitch_in, // Short bounce on all contacts
  output logic [5:0] pin_out // Levels seen at the pins
);
  // ----------------------------------------------------------------
  // Contact levels
  // ----------------------------------------------------------------
  // A bounce flips every contact, so a missed filter shows in any bit
  always_ff @(posedge clk_in) begin
    pin_out <= glitch_in ? ~level_in : level_in;
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the input conditioning block with a switch model.
// Assumes an 8-cycle sampling period and one 100 MHz clock.
`timescale 1ns/1ps

module tb_top;
  localparam int MS = 8;
  logic clk, rst, wr, rd, enc_a, enc_b, enc_i, net, sdm, glitch, ack, err, dm, nl, pl, hm, st, dr;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [31:0] wdata, rdata, img, rv, e;
  logic [5:0] pins, lvl, th;
  logic [7:0] codes [20] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10,
    8'h44, 8'h45, 8'h46, 8'h48, 8'h80, 8'h83, 8'h90, 8'hC4, 8'hC5, 8'hC6, 8'hC8};
  logic [7:0] subs [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08};
  int err_count, comparisons, cyc;
  dic_pkg::dic_cfg_t cfg;

  dic_sw_model i_dic_sw_model (.clk_in(clk), .level_in(lvl), .glitch_in(glitch), .pin_out(pins));
  dic_input_cond #(.MS_CYCLES(MS)) i_dic_input_cond (.CLOCK_IN(clk), .RESET_IN(rst),
    .PIN_IN(pins), .ENC_A_IN(enc_a), .ENC_B_IN(enc_b), .ENC_IDX_IN(enc_i),
    .NET_ACTIVE_IN(net), .STEP_DIR_MODE_IN(sdm), .OBJ_WR_IN(wr), .OBJ_RD_IN(rd),
    .OBJ_INDEX_IN(idx), .OBJ_SUB_IN(sub), .OBJ_WDATA_IN(wdata), .OBJ_RDATA_OUT(rdata),
    .OBJ_ACK_OUT(ack), .OBJ_ERR_OUT(err), .IMAGE_OUT(img), .THRESH_24V_OUT(th),
    .DIFF_MODE_OUT(dm), .NEG_LIMIT_OUT(nl), .POS_LIMIT_OUT(pl), .HOME_OUT(hm),
    .STEP_OUT(st), .DIR_OUT(dr));

  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  // Pin pairs: odd index is the true line, even index the complement
  function automatic logic [5:0] phys(input logic [5:0] p, input logic d);
    phys = d ? {3'h0, p[5] & ~p[4], p[3] & ~p[2], p[1] & ~p[0]} : p;
  endfunction

  function automatic logic [5:0] forced(input logic [5:0] p, input dic_pkg::dic_cfg_t c);
    forced = (c.force_en[5:0] & c.force_val[5:0]) | (~c.force_en[5:0] & phys(p, c.diff));
  endfunction

  function automatic logic [31:0] exp_img(input logic [5:0] p, input dic_pkg::dic_cfg_t c,
      input logic s);
    logic [5:0] v;
    v = forced(p, c) ^ c.inv[5:0];
    exp_img = {10'h000, v, 13'h0000, v[2] & c.sfe[2] & ~s, v[1] & c.sfe[1] & ~s, v[0] & c.sfe[0]};
  endfunction

  // Unknown codes read 0 before the invert bit applies
  function automatic logic src(input logic [7:0] code, input logic [5:0] f);
    logic b;
    case (code[6:0])
      7'h44: b = enc_a;
      7'h45: b = enc_b;
      7'h46: b = enc_i;
      7'h48: b = net;
      default: b = (code[6:0] >= 7'h01 && code[6:0] <= 7'h06) ? f[code[2:0] - 3'h1] : 1'b0;
    endcase
    src = b ^ code[7];
  endfunction

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] x, input logic [31:0] s);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, x, s);
    end
  endtask

  // One access; the answer lands exactly one cycle after the strobe
  task automatic obj(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d, input logic x_err);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    idx <= i;
    sub <= s;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    chk("ack", 1, ack);
    chk("err", x_err, err);
    rv = rdata;
  endtask

  task automatic wcfg();
    obj(1, 16'h3240, 8'h01, cfg.sfe, 0);
    obj(1, 16'h3240, 8'h02, cfg.inv, 0);
    obj(1, 16'h3240, 8'h03, cfg.force_en, 0);
    obj(1, 16'h3240, 8'h04, cfg.force_val, 0);
    obj(1, 16'h3240, 8'h06, cfg.thresh, 0);
    obj(1, 16'h3240, 8'h07, {31'h0000_0000, cfg.diff}, 0);
  endtask

  // Settings land at the next tick, so wait out several periods
  task automatic check_all(input string name);
    repeat (3 * MS) @(posedge clk);
    #1;
    e = exp_img(lvl, cfg, sdm);
    chk("image", e, img);
    chk("specials", {29'h0000_0000, e[2:0]}, {29'h0000_0000, hm, pl, nl});
    obj(0, 16'h60FD, 8'h00, 0, 0);
    chk("image object", e, rv);
    chk("thresh", {26'h000_0000, cfg.thresh[5:0]}, {26'h000_0000, th});
    chk("diff", {31'h0000_0000, cfg.diff}, {31'h0000_0000, dm});
    e[5:0] = phys(lvl, cfg.diff);
    chk("stepdir", {30'h0000_0000, sdm & e[2], sdm & e[1]}, {30'h0000_0000, st, dr});
    obj(0, 16'h3240, 8'h05, 0, 0);
    chk("raw", {26'h000_0000, e[5:0]}, rv);
    $display("Test %s done", name);
  endtask

  task automatic finish_test();
    $display("Counts: mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, cycle count and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= rst ? 0 : cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, wr, rd, enc_a, enc_b, enc_i, net, sdm, glitch} = 9'h100;
    {idx, sub, wdata, lvl, cyc, err_count, comparisons} = '0;
    cfg = '0;
    rv = $urandom(1291);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (subs[k]) begin
      obj(0, 16'h3240, subs[k], 0, 0);
      chk("reset value", 0, rv);
    end
    // Read-only and unmapped places are refused and store nothing
    obj(1, 16'h3240, 8'h05, 32'hFFFF_FFFF, 1);
    obj(1, 16'h60FD, 8'h00, 32'hFFFF_FFFF, 1);
    obj(0, 16'h1234, 8'h00, 0, 1);
    chk("unmapped", 0, rv);
    check_all("refusal");
    // Bounce kept well clear of the tick cycle
    @(posedge clk);
    while (cyc % MS != 0) @(posedge clk);
    glitch <= 1'b1;
    repeat (3) @(posedge clk);
    glitch <= 1'b0;
    // Pins are back to steady levels here; the image must not have followed the bounce
    @(posedge clk);
    #1;
    chk("glitch image", exp_img(lvl, cfg, sdm), img);
    check_all("glitch");
    for (int i = 0; i < 14; i++) begin
      cfg = {$urandom, $urandom, $urandom, $urandom, $urandom, 2'(i > 1 ? $urandom : 0)};
      if (i == 0) cfg.sfe = 32'hFFFF_FFFF;
      if (i == 1) {cfg.force_en, cfg.force_val} = {32'hFFFF_FFFF, 32'h0000_002A};
      if (i == 2) cfg.diff = 1'b1;
      wcfg();
      @(posedge clk);
      lvl <= 6'($urandom);
      sdm <= i[0];
      check_all("random");
    end
    cfg.sfe = 32'h0000_0007;
    cfg.diff = 1'b0;
    wcfg();
    @(posedge clk);
    sdm <= 1'b0;
    {enc_a, enc_b, enc_i, net} <= 4'($urandom);
    check_all("before routing");
    obj(1, 16'h3240, 8'h08, 1, 0);
    obj(0, 16'h3242, 8'h11, 0, 0);
    chk("default entry", {24'h00_0000, cfg.inv[0], 7'h01}, rv);
    check_all("routing on");
    obj(1, 16'h3242, 8'h20, 8'h80, 0);
    foreach (codes[k]) begin
      obj(1, 16'h3242, 8'h01, codes[k], 0);
      obj(0, 16'h3242, 8'h01, 0, 0);
      chk("entry", {24'h00_0000, codes[k]}, rv);
      repeat (3 * MS) @(posedge clk);
      #1;
      chk("routed bits", {1'b1, 30'h0000_0000, src(codes[k], forced(lvl, cfg))},
        {img[31], 30'h0000_0000, img[0]});
    end
    $display("Test codes done");
    obj(1, 16'h3240, 8'h08, 0, 0);
    check_all("routing off");
    finish_test();
  end
endmodule
